// *** rtl/fpr_pkg.sv ***
package fpr_pkg;

  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Supply setup to first access, in microseconds.
  localparam int unsigned CORE_SUPPLY_SETUP_US = 300;
  localparam int unsigned IO_SUPPLY_SETUP_US = 300;
  // Reset low to select low, in microseconds.
  localparam int unsigned RESET_TO_SELECT_US = 35;
  // Reset pulse width, reset high gap and select high pulse, in nanoseconds.
  localparam int unsigned RESET_PULSE_NS = 200;
  localparam int unsigned RESET_HIGH_GAP_NS = 50;
  localparam int unsigned SELECT_HIGH_NS = 20;

  localparam int unsigned SUPPLY_US_MAX = (CORE_SUPPLY_SETUP_US > IO_SUPPLY_SETUP_US) ?
                                          CORE_SUPPLY_SETUP_US : IO_SUPPLY_SETUP_US;
  localparam int unsigned SUPPLY_CYC = SUPPLY_US_MAX * CLK_MHZ;
  localparam int unsigned RESET_TO_SELECT_CYC = RESET_TO_SELECT_US * CLK_MHZ;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_HIGH_GAP_CYC =
    (RESET_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELECT_HIGH_CYC = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 18;

  typedef enum logic [2:0] {
    FPR_POWER_WAIT = 3'h0,
    FPR_RESET_LOW  = 3'h1,
    FPR_RESET_GAP  = 3'h2,
    FPR_READY      = 3'h3,
    FPR_ACCESS     = 3'h4,
    FPR_SEL_HIGH   = 3'h5
  } fpr_state_t;

  typedef struct packed {
    logic reset_n;
    logic select_n;
  } fpr_pins_t;

endpackage : fpr_pkg

// *** rtl/fpr_host.sv ***
`timescale 1ns/1ps
// How it works
// [R1] First access waits 300 us after supplies reach their operating level.
// [R2] After reset falls, select stays high at least 35 us.
// [R3] Reset stays high at least 50 ns before select falls.
// [R4] Select high between accesses lasts at least 20 ns.
// [R5] Reset pulse plus high gap together cover the 35 us interval.
// [R6] Reset during power-up still meets 200 ns pulse and 35 us interval.
// [R7] Reset held past supply setup measures 35 us from its end.
// [R8] Device starts configuration loading on power-up; host just waits.
// [R9] Device ignores controls during cold reset; host keeps select high.
// [R10] Each access after cold reset begins with a select falling edge.
// [R11] Device enters hardware reset or standby by reset level at cold end.
// [R12] Reset before cold reset ends makes the device rerun cold reset; the flash model ignores reset until the cold load ends.
// [R13] Reset after standby starts the device warm reset algorithm.
// [R14] Warm reset aborts embedded algorithms without reloading them.
// [R15] Device stays in reset while reset low, else goes to standby.
// [R16] Incomplete power-on reset makes a later reset rerun cold reset.
// [R17] Device drives ready/busy low during cold or warm reset.
// [R18] Device begins hardware reset when reset pin goes low.
// [R19] After the reset interval the device sits in standby until access.
// [R20] Sequencer uses explicit states and counters against set durations.
module fpr_host
  import fpr_pkg::*;
#(
  parameter int unsigned SUPPLY_CYCLES = SUPPLY_CYC,
  parameter int unsigned RESET_SELECT_CYCLES = RESET_TO_SELECT_CYC
)
(
  input wire logic core_clk, // System clock, 25 MHz.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic power_good, // Both supplies at minimum operating level.
  input wire logic reset_req, // Pulse: request a warm reset of the flash.
  input wire logic access_req, // Level: user wants the select low.
  input wire logic ready_busy_out, // Flash ready/busy pin, low while busy.
  output fpr_pins_t pins, // Reset and select strobes to the flash.
  output logic access_ready, // Select may go low now.
  output logic access_active, // Select is low.
  output logic flash_busy // Synchronised busy indication.
);

  fpr_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] rst_cnt_q, rst_cnt_d;
  logic rst_pend_q, rst_pend_d;
  logic pg_s1_q, pg_s2_q, rb_s1_q, rb_s2_q;
  fpr_pins_t pins_q, pins_d;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pg_s1_q <= 1'b0;
      pg_s2_q <= 1'b0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end
    else
    begin
      pg_s1_q <= power_good;
      pg_s2_q <= pg_s1_q;
      rb_s1_q <= ready_busy_out;
      rb_s2_q <= rb_s1_q;
    end
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    rst_cnt_d = rst_cnt_q;
    pins_d = pins_q;
    rst_pend_d = rst_pend_q | reset_req;
    if (rst_cnt_q != '0)
    begin
      rst_cnt_d = rst_cnt_q - 1'b1;
    end
    case (state_q)
      FPR_POWER_WAIT:
      begin
        // [R9] Select held high through cold reset.
        pins_d.select_n = 1'b1;
        if (!pg_s2_q)
        begin
          cnt_d = '0;
        end
        // [R1] Supply setup before first access.
        else if (cnt_q < CNT_W'(SUPPLY_CYCLES))
        begin
          cnt_d = cnt_q + 1'b1;
        end
        else if (rst_pend_q || !pins_q.reset_n)
        begin
          // [R7] Reset interval counted from the end of supply setup.
          pins_d.reset_n = 1'b0;
          // A request arriving in the launch cycle stays pending, so it is never lost.
          rst_pend_d = reset_req;
          rst_cnt_d = CNT_W'(RESET_SELECT_CYCLES);
          cnt_d = '0;
          state_d = FPR_RESET_LOW;
        end
        else
        begin
          cnt_d = '0;
          state_d = FPR_RESET_GAP;
        end
      end
      FPR_RESET_LOW:
      begin
        cnt_d = cnt_q + 1'b1;
        // [R6] Pulse width and full interval both satisfied.
        // [R5] Low time plus gap covers the reset-to-select interval.
        if (cnt_q >= CNT_W'(RESET_PULSE_CYC - 1) &&
            rst_cnt_q <= CNT_W'(RESET_HIGH_GAP_CYC + 1))
        begin
          pins_d.reset_n = 1'b1;
          cnt_d = '0;
          state_d = FPR_RESET_GAP;
        end
      end
      FPR_RESET_GAP:
      begin
        cnt_d = cnt_q + 1'b1;
        // [R3] Reset high gap before select falls.
        // [R2] Select stays high for the reset-to-select interval.
        if (cnt_q >= CNT_W'(RESET_HIGH_GAP_CYC - 1) && rst_cnt_q == '0)
        begin
          cnt_d = '0;
          state_d = FPR_READY;
        end
      end
      FPR_READY:
      begin
        if (rst_pend_q)
        begin
          // [R18] Driving reset low starts a device hardware reset.
          pins_d.reset_n = 1'b0;
          rst_pend_d = reset_req;
          rst_cnt_d = CNT_W'(RESET_SELECT_CYCLES);
          cnt_d = '0;
          state_d = FPR_RESET_LOW;
        end
        else if (access_req && rb_s2_q)
        begin
          // [R10] Every access starts with a falling select edge.
          pins_d.select_n = 1'b0;
          state_d = FPR_ACCESS;
        end
      end
      FPR_ACCESS:
      begin
        if (!access_req || rst_pend_q)
        begin
          pins_d.select_n = 1'b1;
          cnt_d = '0;
          state_d = FPR_SEL_HIGH;
        end
      end
      FPR_SEL_HIGH:
      begin
        cnt_d = cnt_q + 1'b1;
        // [R4] Minimum select high pulse.
        if (cnt_q >= CNT_W'(SELECT_HIGH_CYC - 1))
        begin
          cnt_d = '0;
          state_d = FPR_READY;
        end
      end
      default:
      begin
        state_d = FPR_POWER_WAIT;
        pins_d = '{reset_n: 1'b1, select_n: 1'b1};
      end
    endcase
  end

  // [R20] Explicit sequencer state with duration counters.
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= FPR_POWER_WAIT;
      cnt_q <= '0;
      rst_cnt_q <= '0;
      rst_pend_q <= 1'b0;
      pins_q <= '{reset_n: 1'b1, select_n: 1'b1};
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rst_cnt_q <= rst_cnt_d;
      rst_pend_q <= rst_pend_d;
      pins_q <= pins_d;
    end
  end

  assign pins = pins_q;
  assign access_ready = (state_q == FPR_READY) && !rst_pend_q && rb_s2_q;
  assign access_active = !pins_q.select_n;
  // [R17] Device busy seen through the synchronised ready/busy pin.
  assign flash_busy = !rb_s2_q;

  // [R3] Reset must have been high for the gap when select falls.
  a_reset_gap_select: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(pins_q.select_n) |-> $past(pins_q.reset_n, 1) && $past(pins_q.reset_n, 2))
    else $error("Select fell without reset high gap.");

  // [R6] Reset low pulse lasts at least its minimum.
  a_reset_pulse_min: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(pins_q.reset_n) |=> !pins_q.reset_n [*4])
    else $error("Reset pulse too short.");

  // [R4] Select high pulse lasts at least two cycles.
  a_select_high_min: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(pins_q.select_n) |=> pins_q.select_n)
    else $error("Select high pulse too short.");

  // [R2] Select stays high while the reset interval runs.
  a_select_hold_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    (rst_cnt_q != '0) |-> pins_q.select_n)
    else $error("Select low during reset interval.");

  // [R1] Select stays high until the supply setup has elapsed.
  a_supply_wait: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FPR_POWER_WAIT) |-> pins_q.select_n)
    else $error("Select low before supply setup.");

  // [R18] A pending reset in ready drives reset low next cycle.
  a_reset_launch: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == FPR_READY && rst_pend_q) |=> !pins_q.reset_n && state_q == FPR_RESET_LOW)
    else $error("Reset request not launched.");

  // [R5] Reset low time ends only near the end of the interval.
  a_reset_release: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(pins_q.reset_n) |-> $past(rst_cnt_q) <= CNT_W'(RESET_HIGH_GAP_CYC + 1))
    else $error("Reset released too early.");

  // [R10] Select falls only from the ready state.
  a_select_from_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(pins_q.select_n) |-> $past(state_q) == FPR_READY && state_q == FPR_ACCESS)
    else $error("Select fell outside ready.");

endmodule : fpr_host

// *** verification/fpr_flash_model.sv ***
`timescale 1ns/1ps
module fpr_flash_model
  import fpr_pkg::*;
#(
  parameter int unsigned COLD_CYCLES = 15,
  parameter int unsigned WARM_CYCLES = 6
)
(
  input wire logic core_clk, // Bench clock standing in for real time.
  input wire logic power_good, // Supplies inside the operating range.
  input fpr_pins_t pins, // Reset and select strobes from the host.
  output logic ready_busy_out // Low while a reset algorithm runs.
);
  int unsigned cnt;
  logic cold;
  logic warm;
  logic reset_q;
  // Power rising from below the reset level restarts the cold load.
  always @(posedge core_clk or negedge power_good)
  begin
    if (!power_good)
    begin
      cold <= 1'b1;
      warm <= 1'b0;
      cnt <= 0;
    end
    else if (cold)
    begin
      // Strobes are ignored until the load ends; the reset level then decides.
      cnt <= cnt + 1;
      if (cnt + 1 >= COLD_CYCLES)
        cold <= 1'b0;
    end
    else if (reset_q && !pins.reset_n)
    begin
      // A reset fall from standby starts the short warm algorithm.
      warm <= 1'b1;
      cnt <= 0;
    end
    else if (warm)
    begin
      // After the warm run the level of reset alone holds the device.
      cnt <= cnt + 1;
      if (cnt + 1 >= WARM_CYCLES)
        warm <= 1'b0;
    end
  end
  always @(posedge core_clk)
    reset_q <= pins.reset_n;
  // Busy stays low through both reset algorithms.
  assign ready_busy_out = !(cold || warm) && pins.reset_n;
endmodule : fpr_flash_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import fpr_pkg::*;
  localparam int unsigned SUP = 20;
  localparam int unsigned RSC = 10;
  logic core_clk = 1'b0, sys_rst = 1'b1, power_good = 1'b0, reset_req = 1'b0;
  logic access_req = 1'b0, rb, access_ready, access_active, flash_busy;
  fpr_pins_t pins;
  int err_total = 0, compares = 0, since_pg = 0, since_fall = 0, hi_cnt = 0, sel_hi = 0;
  int lo_cnt = 0, i, n;
  logic [31:0] seed = 32'h3E5CD9C0, r;
  fpr_pins_t prev;
  fpr_host #(.SUPPLY_CYCLES(SUP), .RESET_SELECT_CYCLES(RSC)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .power_good(power_good), .reset_req(reset_req),
    .access_req(access_req), .ready_busy_out(rb), .pins(pins), .access_ready(access_ready),
    .access_active(access_active), .flash_busy(flash_busy));
  fpr_flash_model u_flash (.core_clk(core_clk), .power_good(power_good), .pins(pins),
    .ready_busy_out(rb));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic test_done();
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  // Interval monitor on the strobe pins.
  always @(posedge core_clk)
  begin
    since_pg <= power_good ? since_pg + 1 : 0;
    since_fall <= (prev.reset_n && !pins.reset_n) ? 1 : since_fall + 1;
    hi_cnt <= pins.reset_n ? hi_cnt + 1 : 0;
    lo_cnt <= pins.reset_n ? 0 : lo_cnt + 1;
    sel_hi <= pins.select_n ? sel_hi + 1 : 0;
    if (!sys_rst && prev.select_n && !pins.select_n)
    begin
      `CHK("supply_wait", 1'b1, since_pg >= SUP)
      `CHK("reset_to_select", 1'b1, since_fall >= RSC)
      `CHK("reset_high_gap", 1'b1, hi_cnt >= RESET_HIGH_GAP_CYC)
      `CHK("select_high", 1'b1, sel_hi >= SELECT_HIGH_CYC)
      `CHK("flash_ready", 1'b1, rb)
    end
    if (!sys_rst && !prev.reset_n && pins.reset_n)
      `CHK("reset_pulse", 1'b1, lo_cnt >= RESET_PULSE_CYC)
    // Busy reaches the host two synchroniser stages after reset falls.
    if (!sys_rst && lo_cnt >= 2)
      `CHK("busy_in_reset", 1'b1, flash_busy)
    if (!sys_rst && access_ready)
      `CHK("ready_idle", 2'b11, {pins.reset_n, pins.select_n})
    if (!sys_rst)
      `CHK("active_tracks", !pins.select_n, access_active)
    prev <= pins;
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    reset_req <= 1'b1;
    @(posedge core_clk) reset_req <= 1'b0;
    power_good <= 1'b1;
    // A short supply dip must restart the setup wait.
    repeat (5) @(posedge core_clk);
    power_good <= 1'b0;
    repeat (3) @(posedge core_clk);
    power_good <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      r = seed;
      n = 0;
      while (access_ready !== 1'b1 && n < 3000)
      begin
        @(posedge core_clk);
        n++;
      end
      `CHK("ready_wait", 1'b1, n < 3000)
      `CHK("busy_at_ready", 1'b0, flash_busy)
      access_req <= 1'b1;
      repeat (r[2:0] + 2) @(posedge core_clk);
      if (r[8])
      begin
        reset_req <= 1'b1;
        @(posedge core_clk) reset_req <= 1'b0;
      end
      access_req <= 1'b0;
      @(posedge core_clk);
      if (r[9])
        repeat (r[6:4]) @(posedge core_clk);
    end
    // A mid-run system reset with no request pending skips the reset pulse.
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    n = 0;
    while (access_ready !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    `CHK("rerun_ready", 1'b1, n < 3000)
    access_req <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("rerun_access", 1'b1, access_active)
    access_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    test_done();
  end
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    test_done();
  end
endmodule : tb_top
